// [include/nvmewc_pkg.sv]
// Shared constants and types of the data EEPROM write controller.
package nvmewc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_CONTROL = 16'h0760;
  localparam logic [15:0] OFS_ADDR_LOW = 16'h0762;
  localparam logic [15:0] OFS_ADDR_UPPER = 16'h0764;
  localparam logic [15:0] OFS_UNLOCK_KEY = 16'h0766;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_START = 15;
  localparam int unsigned BIT_ALLOW = 14;
  localparam int unsigned BIT_FAULT = 13;
  localparam int unsigned BIT_TSEL = 8;
  localparam int unsigned OP_MSB = 6;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0] ADDR_UPPER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Unlock keys and operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_WORD_ERASE = 7'h44;
  localparam logic [6:0] OP_WORD_PROG = 7'h04;
  localparam logic [6:0] OP_BLOCK_PROG = 7'h0A;

  // ----------------------------------------------------------------
  // Data EEPROM region
  // ----------------------------------------------------------------
  localparam logic [23:0] EE_BASE = 24'h7F_F000;
  localparam logic [23:0] EE_LAST = 24'h7F_FFFE;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_TIME_NS = 1000;
  localparam int unsigned CYCLE_TIME_MS = 2;
  localparam int unsigned TICK_CLOCKS = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_TICKS_DEF =
    CYCLE_TIME_MS * 1000000 / TICK_TIME_NS;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} nvmewc_key_t;

endpackage

// [include/nvmewc_cycle_if.sv]
// Handshake between the register front end and the cycle timer.
`timescale 1ns/100ps
`default_nettype none
interface nvmewc_cycle_if;
  logic start;
  logic abort;
  logic busy;
  logic done;
  modport ctrl (output start, output abort, input busy, input done);
  modport timer (input start, input abort, output busy, output done);
endinterface
`default_nettype wire

// [hdl/nvmewc_cycle_timer.sv]
// Background erase and program cycle timer.
`timescale 1ns/100ps
`default_nettype none
module nvmewc_cycle_timer
  import nvmewc_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = CYCLE_TICKS_DEF
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Cycle handshake.
  nvmewc_cycle_if.timer cyc
);

  localparam int unsigned DIV_W = $clog2(TICK_CLOCKS);

  if (CYCLE_TICKS < 1 || CYCLE_TICKS > 65535 || TICK_CLOCKS < 2)
  begin : bad_timing
    $error("Cycle timing parameters out of range.");
  end

  logic [DIV_W-1:0] div_cnt;
  logic [15:0] tick_cnt;
  logic tick;
  int unsigned elapsed;

  assign tick = (div_cnt == DIV_W'(TICK_CLOCKS - 1));

  // ----------------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || cyc.abort)
    begin
      cyc.busy <= 1'b0;
      cyc.done <= 1'b0;
      div_cnt <= '0;
      tick_cnt <= '0;
    end
    else
    begin
      cyc.done <= 1'b0;
      if (cyc.start && !cyc.busy)
      begin
        cyc.busy <= 1'b1;
        div_cnt <= '0;
        tick_cnt <= '0;
      end
      else if (cyc.busy)
      begin
        if (tick)
        begin
          div_cnt <= '0;
          if (tick_cnt == 16'(CYCLE_TICKS - 1))
          begin
            cyc.busy <= 1'b0;
            cyc.done <= 1'b1;
          end
          else
          begin
            tick_cnt <= tick_cnt + 16'h0001;
          end
        end
        else
        begin
          div_cnt <= div_cnt + DIV_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (cyc.start && !cyc.busy))
      elapsed <= 0;
    else if (cyc.busy)
      elapsed <= elapsed + 1;
  end

  sequence cycle_start_s;
    cyc.start && !cyc.busy && !cyc.abort;
  endsequence

  property cycle_runs_p;
    @(posedge ref_clk) disable iff (sys_rst || cyc.abort)
      cycle_start_s |=> cyc.busy [*8];
  endproperty

  cycle_runs_a: assert property (cycle_runs_p)
    else $error("Cycle ended too early.");

  cycle_length_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst || cyc.abort)
      $rose(cyc.done) |-> elapsed == CYCLE_TICKS * TICK_CLOCKS)
    else $error("Cycle length wrong.");

endmodule
`default_nettype wire

// [hdl/nvmewc_top.sv]
// Data EEPROM write controller with unlock sequence and cycle timing.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Start needs 0x55 then 0xAA key writes.
// - Start bit set by software, cleared by hardware.
// - Write-allow needed; cleared at power-up.
// - Hardware clears write-allow only on a reset, pin and watchdog included.
// - Clearing write-allow does not stop cycle.
// - Write-allow must precede start, not together.
// - Pin or watchdog reset mid-cycle sets fault.
// - Lower address survives interrupting reset.
// - Completion clears start, sets sticky done flag.
// - Cycle runs in background, no stall.
// - Array reads invalid during a cycle.
// - Cycle timed internally, about 2 ms.
// - Word or 16-word block erase and program.
// - Targets lie in the data EEPROM region.
// - Target combines upper and lower address.
// - Codes 0x4045 block erase, 0x4044 word erase.
// - Codes 0x4004 word program, 0x400A block program.
// - Lower address captures table instruction address.
module nvmewc_top
  import nvmewc_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = CYCLE_TICKS_DEF
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Warm resets.
  input wire logic external_reset_pin_n,
  input wire logic wdt_reset,
  // Special-function register port.
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [15:0] sfr_wdata,
  output logic [15:0] sfr_rdata,
  // Table instruction address capture.
  input wire logic tbl_exec,
  input wire logic [23:0] tbl_ea,
  // Completion flag.
  input wire logic done_flag_clear,
  output logic write_done_flag,
  // Array control.
  output logic array_erase,
  output logic array_program,
  output logic array_block,
  output logic [23:0] array_addr,
  output logic array_read_valid
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  nvmewc_cycle_if cyc ();

  logic pin_meta;
  logic pin_sync;
  logic warm;
  logic warm_q;
  logic ctl_write;
  logic low_write;
  logic upper_write;
  logic key_access;
  logic key_write;
  logic go;
  logic op_ok;
  logic region_ok;
  logic [23:0] target;
  logic [15:0] ctl_view;
  nvmewc_key_t key_state;

  logic cycle_start_bit;
  logic write_allow;
  logic write_fault;
  logic timing_select_bit;
  logic [6:0] operation_select;
  logic [15:0] address_low;
  logic [7:0] address_upper;

  function automatic logic op_legal(input logic [6:0] op);
    return op inside {OP_BLOCK_ERASE, OP_WORD_ERASE,
                      OP_WORD_PROG, OP_BLOCK_PROG};
  endfunction

  // ----------------------------------------------------------------
  // Warm reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      warm_q <= 1'b0;
    end
    else
    begin
      pin_meta <= external_reset_pin_n;
      pin_sync <= pin_meta;
      warm_q <= warm;
    end
  end

  assign warm = !pin_sync || wdt_reset;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign ctl_write = sfr_wr_en && (sfr_addr == OFS_CONTROL);
  assign low_write = sfr_wr_en && (sfr_addr == OFS_ADDR_LOW);
  assign upper_write = sfr_wr_en && (sfr_addr == OFS_ADDR_UPPER);
  assign key_access = (sfr_wr_en || sfr_rd_en) &&
                      (sfr_addr == OFS_UNLOCK_KEY);
  assign key_write = key_access && sfr_wr_en;

  assign target = {address_upper, address_low};
  assign region_ok = (target >= EE_BASE) && (target <= EE_LAST);
  assign op_ok = op_legal(sfr_wdata[OP_MSB:0]);

  // Start is taken only with a fresh unlock, a prior write-allow,
  // a legal operation and no cycle already running.
  assign go = ctl_write && sfr_wdata[BIT_START] &&
              (key_state == KEY_ARMED) &&
              write_allow &&
              !cycle_start_bit &&
              op_ok && region_ok;

  assign cyc.start = go;
  assign cyc.abort = warm;

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || warm)
    begin
      key_state <= KEY_IDLE;
    end
    else if (key_access)
    begin
      unique case (key_state)
        KEY_IDLE:
        begin
          if (key_write && sfr_wdata[7:0] == KEY_FIRST)
            key_state <= KEY_HALF;
        end
        KEY_HALF:
        begin
          if (key_write && sfr_wdata[7:0] == KEY_SECOND)
            key_state <= KEY_ARMED;
          else
            key_state <= KEY_IDLE;
        end
        KEY_ARMED:
        begin
          if (key_write && sfr_wdata[7:0] == KEY_FIRST)
            key_state <= KEY_HALF;
          else
            key_state <= KEY_IDLE;
        end
      endcase
    end
    else if (sfr_wr_en)
    begin
      key_state <= KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cycle_start_bit <= CONTROL_RESET[BIT_START];
      write_allow <= CONTROL_RESET[BIT_ALLOW];
      write_fault <= CONTROL_RESET[BIT_FAULT];
      timing_select_bit <= CONTROL_RESET[BIT_TSEL];
      operation_select <= CONTROL_RESET[OP_MSB:0];
    end
    else if (warm)
    begin
      cycle_start_bit <= CONTROL_RESET[BIT_START];
      write_allow <= CONTROL_RESET[BIT_ALLOW];
      write_fault <= cycle_start_bit || (warm_q && write_fault);
      timing_select_bit <= CONTROL_RESET[BIT_TSEL];
      operation_select <= CONTROL_RESET[OP_MSB:0];
    end
    else
    begin
      if (ctl_write)
      begin
        write_allow <= sfr_wdata[BIT_ALLOW];
        write_fault <= sfr_wdata[BIT_FAULT];
        timing_select_bit <= sfr_wdata[BIT_TSEL];
        operation_select <= sfr_wdata[OP_MSB:0];
      end
      if (go)
        cycle_start_bit <= 1'b1;
      else if (cyc.done)
        cycle_start_bit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Address registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      address_low <= ADDR_LOW_RESET;
      address_upper <= ADDR_UPPER_RESET;
    end
    else
    begin
      // Warm resets leave both registers alone for a retry.
      if (low_write)
        address_low <= sfr_wdata;
      else if (tbl_exec)
        address_low <= tbl_ea[15:0];
      if (upper_write)
        address_upper <= sfr_wdata[7:0];
      else if (tbl_exec)
        address_upper <= tbl_ea[23:16];
    end
  end

  // ----------------------------------------------------------------
  // Completion flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || warm)
      write_done_flag <= 1'b0;
    else if (cyc.done)
      write_done_flag <= 1'b1;
    else if (done_flag_clear)
      write_done_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Array control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || warm || cyc.done)
    begin
      array_erase <= 1'b0;
      array_program <= 1'b0;
      array_block <= 1'b0;
      array_read_valid <= 1'b1;
    end
    else if (go)
    begin
      array_erase <= sfr_wdata[6];
      array_program <= !sfr_wdata[6];
      array_block <= sfr_wdata[OP_MSB:0] == OP_BLOCK_ERASE ||
                     sfr_wdata[OP_MSB:0] == OP_BLOCK_PROG;
      array_read_valid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      array_addr <= '0;
    else if (go)
      array_addr <= target;
  end

  // The cycle runs beside the core; no stall reaches it.
  nvmewc_cycle_timer #(
    .CYCLE_TICKS(CYCLE_TICKS)
  ) u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cyc(cyc)
  );

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl_view = '0;
    ctl_view[BIT_START] = cycle_start_bit;
    ctl_view[BIT_ALLOW] = write_allow;
    ctl_view[BIT_FAULT] = write_fault;
    ctl_view[BIT_TSEL] = timing_select_bit;
    ctl_view[OP_MSB:0] = operation_select;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      sfr_rdata <= '0;
    end
    else if (sfr_rd_en)
    begin
      unique case (sfr_addr)
        OFS_CONTROL: sfr_rdata <= ctl_view;
        OFS_ADDR_LOW: sfr_rdata <= address_low;
        OFS_ADDR_UPPER: sfr_rdata <= {8'h00, address_upper};
        default: sfr_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence key_first_s;
    key_write && sfr_wdata[7:0] == KEY_FIRST && key_state == KEY_IDLE &&
    !warm;
  endsequence

  sequence key_second_s;
    key_write && sfr_wdata[7:0] == KEY_SECOND && !warm;
  endsequence

  key_gate_a: assert property (go |-> key_state == KEY_ARMED)
    else $error("Start without unlock.");

  key_pair_a: assert property (
    key_first_s ##1 (!sfr_wr_en && !sfr_rd_en && !warm) ##1 key_second_s
      |=> key_state == KEY_ARMED)
    else $error("Key pair not accepted.");

  start_hold_a: assert property (
    cycle_start_bit && !cyc.done && !warm |=> cycle_start_bit)
    else $error("Start bit dropped early.");

  allow_needed_a: assert property (go |-> write_allow)
    else $error("Start without write allow.");

  allow_kept_a: assert property (
    !ctl_write && !warm |=> $stable(write_allow))
    else $error("Write allow changed by hardware.");

  allow_drop_a: assert property (
    cycle_start_bit && ctl_write && !sfr_wdata[BIT_ALLOW] && !warm &&
    !cyc.done |=> cycle_start_bit && (cyc.busy || cyc.done))
    else $error("Cycle stopped by write allow.");

  same_write_a: assert property (
    ctl_write && !write_allow && !cycle_start_bit |=> !cycle_start_bit)
    else $error("Start set with write allow.");

  fault_set_a: assert property (
    warm && cycle_start_bit |=> write_fault && !cycle_start_bit)
    else $error("Interrupted cycle not flagged.");

  addr_kept_a: assert property (
    warm && !low_write && !tbl_exec |=> $stable(address_low))
    else $error("Address lost on warm reset.");

  done_flag_a: assert property (
    cyc.done && !warm |=> write_done_flag && !cycle_start_bit)
    else $error("Completion not reported.");

  read_guard_a: assert property (
    cycle_start_bit |-> !array_read_valid)
    else $error("Read valid during cycle.");

  region_a: assert property (go |-> region_ok)
    else $error("Target outside region.");

  table_cap_a: assert property (
    tbl_exec && !low_write |=> address_low == $past(tbl_ea[15:0]))
    else $error("Table address not captured.");

  one_shot_a: assert property (
    go && !warm |=> key_state == KEY_IDLE ##1 !go)
    else $error("Unlock used twice.");

endmodule
`default_nettype wire

// [tb/nvmewc_core_model.sv]
// Processor core model issuing register, table and flag-clear requests.
`timescale 1ns/100ps
`default_nettype none
module nvmewc_core_model
  import nvmewc_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Register port.
  output logic [15:0] sfr_addr,
  output logic sfr_wr_en,
  output logic sfr_rd_en,
  output logic [15:0] sfr_wdata,
  input wire logic [15:0] sfr_rdata,
  // Table instruction and flag clear.
  output logic tbl_exec,
  output logic [23:0] tbl_ea,
  output logic done_flag_clear
);
  initial
  begin
    sfr_addr = 16'h0000;
    sfr_wr_en = 1'b0;
    sfr_rd_en = 1'b0;
    sfr_wdata = 16'h0000;
    tbl_exec = 1'b0;
    tbl_ea = 24'h00_0000;
    done_flag_clear = 1'b0;
  end
  // Released data lines show the inverse of the last value.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge ref_clk);
    sfr_wr_en = 1'b0;
    sfr_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    @(negedge ref_clk);
    sfr_rd_en = 1'b0;
    d = sfr_rdata;
  endtask
  task automatic tbl(input logic [23:0] ea);
    @(negedge ref_clk);
    tbl_ea = ea;
    tbl_exec = 1'b1;
    @(negedge ref_clk);
    tbl_exec = 1'b0;
    tbl_ea = ~ea;
  endtask
  task automatic clr();
    @(negedge ref_clk);
    done_flag_clear = 1'b1;
    @(negedge ref_clk);
    done_flag_clear = 1'b0;
  endtask
  task automatic unlock();
    wr(OFS_UNLOCK_KEY, {8'h00, KEY_FIRST});
    wr(OFS_UNLOCK_KEY, {8'h00, KEY_SECOND});
  endtask
  // Allow first, then keys, then start, then two idle slots.
  task automatic start(input logic [15:0] code);
    wr(OFS_CONTROL, code);
    unlock();
    wr(OFS_CONTROL, code | 16'h8000);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wait_idle();
    logic [15:0] d;
    for (int n = 0; n < 200; n++)
    begin
      rd(OFS_CONTROL, d);
      if (d[BIT_START] === 1'b0)
        break;
    end
  endtask
endmodule
`default_nettype wire

// [tb/nvmewc_top_test.sv]
// Self-checking testbench of the data EEPROM write controller.
`timescale 1ns/100ps
`default_nettype none
module nvmewc_top_test;
  import nvmewc_pkg::*;
  localparam int unsigned TICKS = 3;
  localparam int RUN_LOW = TICKS * TICK_CLOCKS + 1;
  logic ref_clk, sys_rst, external_reset_pin_n, wdt_reset;
  logic [15:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr_en, sfr_rd_en, tbl_exec, done_flag_clear;
  logic [23:0] tbl_ea, array_addr;
  logic write_done_flag, array_erase, array_program, array_block;
  logic array_read_valid;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int low_run = 0;
  int last_run = 0;

  nvmewc_top #(.CYCLE_TICKS(TICKS)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .external_reset_pin_n(external_reset_pin_n),
    .wdt_reset(wdt_reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .tbl_exec(tbl_exec), .tbl_ea(tbl_ea),
    .done_flag_clear(done_flag_clear), .write_done_flag(write_done_flag),
    .array_erase(array_erase), .array_program(array_program),
    .array_block(array_block), .array_addr(array_addr),
    .array_read_valid(array_read_valid));
  nvmewc_core_model core (.ref_clk(ref_clk), .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .tbl_exec(tbl_exec), .tbl_ea(tbl_ea),
    .done_flag_clear(done_flag_clear));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Length of each stretch with array reads invalid.
  always @(negedge ref_clk)
  begin
    if (array_read_valid === 1'b0)
      low_run++;
    else if (low_run != 0)
    begin
      last_run = low_run;
      low_run = 0;
    end
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [23:0] seen,
    input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic expect_idle(input string name);
    logic [15:0] d;
    core.rd(OFS_CONTROL, d);
    check(name, {23'd0, d[BIT_START]}, 24'd0);
    check("read_valid", {23'd0, array_read_valid}, 24'd1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [15:0] d;
    core.rd(OFS_CONTROL, d);
    check("control", d, CONTROL_RESET);
    core.rd(OFS_UNLOCK_KEY, d);
    check("key", d, 16'h0000);
    core.rd(16'h0768, d);
    check("unmapped", d, 16'h0000);
    check("read_valid", array_read_valid, 1'b1);
    $display("test_reset done");
  endtask
  task automatic test_ops();
    logic [15:0] codes [4] = '{16'h4045, 16'h4044, 16'h4004, 16'h400A};
    logic [15:0] d;
    logic blk;
    for (int i = 0; i < 4; i++)
    begin
      blk = (codes[i] == 16'h4045) || (codes[i] == 16'h400A);
      core.tbl(EE_BASE + 24'(i * 32));
      core.start(codes[i]);
      check("erase", array_erase, codes[i][6]);
      check("program", array_program, !codes[i][6]);
      check("block", array_block, blk);
      check("addr", array_addr, EE_BASE + 24'(i * 32));
      check("read_valid", array_read_valid, 1'b0);
      if (i % 2 == 0)
        core.wr(OFS_CONTROL, codes[i] & 16'h3FFF);
      core.rd(OFS_CONTROL, d);
      check("start_held", d[BIT_START], 1'b1);
      core.wait_idle();
      check("run_len", last_run, RUN_LOW);
      check("done_flag", write_done_flag, 1'b1);
      core.rd(OFS_CONTROL, d);
      check("start_clr", d[BIT_START], 1'b0);
      check("allow", d[BIT_ALLOW], i % 2);
      core.clr();
      check("flag_clr", write_done_flag, 1'b0);
    end
    $display("test_ops done");
  endtask
  task automatic test_refuse();
    core.wr(OFS_CONTROL, 16'h4044);
    core.wr(OFS_CONTROL, 16'hC044);
    expect_idle("no_key");
    core.wr(OFS_UNLOCK_KEY, {8'h00, KEY_SECOND});
    core.wr(OFS_UNLOCK_KEY, {8'h00, KEY_FIRST});
    core.wr(OFS_CONTROL, 16'hC044);
    expect_idle("key_order");
    core.wr(OFS_CONTROL, 16'h0044);
    core.unlock();
    core.wr(OFS_CONTROL, 16'hC044);
    expect_idle("same_write");
    core.wr(OFS_CONTROL, 16'h4044);
    core.wr(OFS_UNLOCK_KEY, {8'h00, KEY_FIRST});
    core.wr(OFS_ADDR_LOW, 16'hF000);
    core.wr(OFS_UNLOCK_KEY, {8'h00, KEY_SECOND});
    core.wr(OFS_CONTROL, 16'hC044);
    expect_idle("broken_key");
    core.start(16'h4044);
    core.wait_idle();
    core.clr();
    core.wr(OFS_CONTROL, 16'hC044);
    expect_idle("reuse");
    $display("test_refuse done");
  endtask
  task automatic test_fault(input logic use_pin);
    logic [15:0] d;
    core.wr(OFS_ADDR_UPPER, 16'h007F);
    core.wr(OFS_ADDR_LOW, 16'hF0A0);
    core.start(16'h4004);
    check("addr", array_addr, 24'h7F_F0A0);
    @(negedge ref_clk);
    external_reset_pin_n = !use_pin;
    wdt_reset = !use_pin;
    @(negedge ref_clk);
    wdt_reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    external_reset_pin_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    core.rd(OFS_CONTROL, d);
    check("fault", d[BIT_FAULT], 1'b1);
    check("start", d[BIT_START], 1'b0);
    core.rd(OFS_ADDR_LOW, d);
    check("addr_kept", d, 16'hF0A0);
    check("read_valid", array_read_valid, 1'b1);
    @(negedge ref_clk);
    wdt_reset = 1'b1;
    @(negedge ref_clk);
    wdt_reset = 1'b0;
    core.rd(OFS_CONTROL, d);
    check("no_fault", d[BIT_FAULT], 1'b0);
    $display("test_fault done");
  endtask

  initial
  begin
    sys_rst = 1'b1;
    external_reset_pin_n = 1'b1;
    wdt_reset = 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    test_reset();
    test_ops();
    test_refuse();
    test_fault(1'b0);
    test_fault(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
